// ### touch_sensor_i2c_slave_behaviour_tb_top.sv
`timescale 1ns/1ps
module touch_sensor_i2c_slave_behaviour_tb_top;
  localparam int BOOT = 20;
  localparam int SAVE = 20;
  logic        clk, rst, bus_act, scan_start, scan_done, touch, acc_req, acc_save;
  logic        scl_oe_n, ack, busy, boot_done, save_ok, save_fail, cnt_vld, trig_stuck, base_frz;
  logic [2:0]  avg_sel;
  logic [1:0]  sleep_sel;
  logic [15:0] raw_cnt, cnt;
  int          n_mismatch, samples_checked;

  tsc_core #(.BOOT_CYC(BOOT), .SAVE_CYC(SAVE)) u_tsc_core (.clk(clk), .rst(rst), .acc_req(acc_req),
    .acc_save(acc_save), .bus_act(bus_act), .sleep_sel(sleep_sel), .avg_sel(avg_sel),
    .scan_start(scan_start), .scan_done(scan_done), .raw_cnt(raw_cnt), .touch(touch), .scl_oe_n(scl_oe_n),
    .ack(ack), .busy(busy), .boot_done(boot_done), .save_ok(save_ok), .save_fail(save_fail),
    .cnt_vld(cnt_vld), .cnt(cnt), .trig_stuck(trig_stuck), .base_frz(base_frz));
  tsc_host_model u_tsc_host_model (.clk(clk), .busy(busy), .ack(ack), .scl_oe_n(scl_oe_n),
    .acc_req(acc_req), .acc_save(acc_save), .sleep_sel(sleep_sel));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ----------------------------------------
  // Shared checking and driving tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Touch and averaging are held through boot, where the power-up flaw bites
  task automatic do_reset(input logic t, input logic [2:0] a);
    int n, lat, st;
    rst = 1'b1;
    touch = t;
    avg_sel = a;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    chk("boot_busy", 16'h0001, 16'(busy));
    u_tsc_host_model.access(1'b0, tsc_pkg::SLP_8HZ, 1'b1, 8, lat, st);
    chk("boot_refused", 16'hffff, 16'(lat));
    n = 0;
    while (boot_done !== 1'b1 && n < BOOT + 50) begin
      @(posedge clk);
      #1 n++;
    end
    if (boot_done !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    touch = 1'b0;
    $display("test reset done");
  endtask : do_reset

  task automatic do_scan(input logic [15:0] raw, input logic noisy, output logic v, output logic [15:0] c);
    int n;
    scan_start = 1'b1;
    @(posedge clk);
    #1 scan_start = 1'b0;
    bus_act = noisy;
    @(posedge clk);
    #1 bus_act = 1'b0;
    scan_done = 1'b1;
    raw_cnt = raw;
    @(posedge clk);
    #1 scan_done = 1'b0;
    v = 1'b0;
    c = 16'h0000;
    n = 0;
    while (v !== 1'b1 && n < 6) begin
      if (cnt_vld === 1'b1) begin
        v = 1'b1;
        c = cnt;
      end else begin
        @(posedge clk);
        #1 n++;
      end
    end
  endtask : do_scan

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_access();
    int lat, st;
    for (int k = 0; k < 2; k++) begin
      u_tsc_host_model.access(1'b0, tsc_pkg::SLP_8HZ, 1'b0, 300, lat, st);
      chk("ack_latency", 16'h0004, 16'(lat));
      chk("stretch_cycles", 16'h0004, 16'(st));
    end
    $display("test access done");
  endtask : test_access

  task automatic test_save();
    logic [1:0] slp [4] = '{tsc_pkg::SLP_8HZ, tsc_pkg::SLP_1HZ, tsc_pkg::SLP_512HZ, tsc_pkg::SLP_64HZ};
    int lat, st, n;
    for (int k = 0; k < 4; k++) begin
      u_tsc_host_model.access(1'b1, slp[k], 1'b0, 300, lat, st);
      chk("save_ack", 16'h0004, 16'(lat));
      u_tsc_host_model.access(1'b0, slp[k], 1'b1, 8, lat, st);
      chk("save_refused", 16'hffff, 16'(lat));
      n = 0;
      while (save_ok !== 1'b1 && save_fail !== 1'b1 && n < SAVE + 40) begin
        @(posedge clk);
        #1 n++;
      end
      chk("save_busy", 16'h0001, 16'(busy));
      chk("save_ok", 16'(k < 2), 16'(save_ok));
      chk("save_fail", 16'(k >= 2), 16'(save_fail));
    end
    $display("test save done");
  endtask : test_save

  task automatic test_filter();
    logic v;
    logic [15:0] c;
    int sum;
    avg_sel = tsc_pkg::AVG_OFF;
    do_scan(16'h1234, 1'b0, v, c);
    chk("plain_cnt", 16'h1234, c);
    do_scan(16'h4321, 1'b1, v, c);
    chk("dropped_vld", 16'h0000, 16'(v));
    for (int s = 1; s <= 4; s++) begin
      avg_sel = 3'(s);
      sum = 0;
      do_scan(16'hffff, 1'b1, v, c);
      for (int i = 0; i < (1 << s); i++) begin
        do_scan(16'(32'h1000 + i * 3), 1'b0, v, c);
        sum += 32'h1000 + i * 3;
      end
      chk("avg_vld", 16'h0001, 16'(v));
      chk("avg_cnt", 16'(sum >> s), c);
    end
    $display("test filter done");
  endtask : test_filter

  task automatic test_touch();
    do_reset(1'b1, 3'h1);
    chk("stuck_avg_on", 16'h0001, 16'(trig_stuck));
    chk("frozen_avg_on", 16'h0001, 16'(base_frz));
    do_reset(1'b1, tsc_pkg::AVG_OFF);
    chk("stuck_avg_off", 16'h0000, 16'(trig_stuck));
    chk("frozen_avg_off", 16'h0000, 16'(base_frz));
    $display("test touch done");
  endtask : test_touch

  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst = 1'b1;
    bus_act = 1'b0;
    scan_start = 1'b0;
    scan_done = 1'b0;
    raw_cnt = 16'h0000;
    touch = 1'b0;
    avg_sel = 3'h0;
    do_reset(1'b0, tsc_pkg::AVG_OFF);
    test_access();
    test_save();
    test_filter();
    test_touch();
    end_of_test();
  end
endmodule : touch_sensor_i2c_slave_behaviour_tb_top

// ### tsc_avg.sv
`timescale 1ns/1ps
module tsc_avg (
  input  wire logic clk,
  input  wire logic rst,
  tsc_avg_if.flt    f
);
  logic [tsc_pkg::ACC_W-1:0] acc_q;
  logic [4:0]                n_q;
  logic [4:0]                lim;
  logic [tsc_pkg::ACC_W-1:0] acc_nx;
  logic [tsc_pkg::ACC_W-1:0] quot;
  assign lim    = 5'h01 << f.avg_sel;
  assign acc_nx = acc_q + tsc_pkg::ACC_W'(f.smp);
  assign quot   = acc_nx >> f.avg_sel;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q     <= '0;
      n_q       <= 5'h00;
      f.out_vld <= 1'b0;
      f.out     <= '0;
    end else begin
      f.out_vld <= 1'b0;
      if (f.smp_vld) begin
        if (f.avg_sel == tsc_pkg::AVG_OFF) begin
          f.out_vld <= 1'b1;
          f.out     <= f.smp;
        end else if (n_q + 5'h01 == lim) begin
          f.out_vld <= 1'b1;
          f.out     <= quot[tsc_pkg::CNT_W-1:0];
          acc_q     <= '0;
          n_q       <= 5'h00;
        end else begin
          acc_q <= acc_nx;
          n_q   <= n_q + 5'h01;
        end
      end
    end
  end
endmodule : tsc_avg

// ### tsc_avg_if.sv
`timescale 1ns/1ps
interface tsc_avg_if;
  logic                       smp_vld;
  logic [tsc_pkg::CNT_W-1:0]  smp;
  logic [2:0]                 avg_sel;
  logic                       out_vld;
  logic [tsc_pkg::CNT_W-1:0]  out;
  modport ctl (output smp_vld, output smp, output avg_sel, input out_vld, input out);
  modport flt (input smp_vld, input smp, input avg_sel, output out_vld, output out);
endinterface : tsc_avg_if

// ### tsc_core.sv
`timescale 1ns/1ps
module tsc_core #(
  parameter int BOOT_CYC = tsc_pkg::BOOT_CYC,
  parameter int SAVE_CYC = tsc_pkg::SAVE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       acc_req,
  input  wire logic                       acc_save,
  input  wire logic                       bus_act,
  input  wire logic [1:0]                 sleep_sel,
  input  wire logic [2:0]                 avg_sel,
  input  wire logic                       scan_start,
  input  wire logic                       scan_done,
  input  wire logic [tsc_pkg::CNT_W-1:0]  raw_cnt,
  input  wire logic                       touch,
  output logic                            scl_oe_n,
  output logic                            ack,
  output logic                            busy,
  output logic                            boot_done,
  output logic                            save_ok,
  output logic                            save_fail,
  output logic                            cnt_vld,
  output logic [tsc_pkg::CNT_W-1:0]       cnt,
  output logic                            trig_stuck,
  output logic                            base_frz
);
  // ------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------
  tsc_pkg::tsc_state_t              st_q;
  tsc_pkg::tsc_state_t              st_d;
  logic [15:0]                      tmr_q;
  logic                             save_q;
  logic                             bad_slp_q;
  logic                             ack_due;
  logic                             save_end;
  logic                             boot_end;
  logic                             bad_slp;
  assign bad_slp  = (sleep_sel == tsc_pkg::SLP_512HZ) || (sleep_sel == tsc_pkg::SLP_64HZ);
  // Ack well inside the bound: four cycles of latency models the firmware turnaround
  assign ack_due  = tmr_q == 16'h0003;
  assign save_end = tmr_q == 16'(SAVE_CYC - 1);
  assign boot_end = tmr_q == 16'(BOOT_CYC - 1);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      tsc_pkg::TSC_BOOT:  if (boot_end) st_d = tsc_pkg::TSC_IDLE;
      tsc_pkg::TSC_IDLE:  if (acc_req) st_d = tsc_pkg::TSC_STRCH;
      tsc_pkg::TSC_STRCH: if (ack_due) st_d = save_q ? tsc_pkg::TSC_SAVE : tsc_pkg::TSC_DONE;
      tsc_pkg::TSC_SAVE:  if (save_end) st_d = tsc_pkg::TSC_DONE;
      tsc_pkg::TSC_DONE:  st_d = tsc_pkg::TSC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= tsc_pkg::TSC_BOOT;
      tmr_q     <= 16'h0000;
      save_q    <= 1'b0;
      bad_slp_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      tmr_q <= (st_d != st_q) ? 16'h0000 : tmr_q + 16'h0001;
      if (st_q == tsc_pkg::TSC_IDLE && acc_req) begin
        save_q    <= acc_save;
        bad_slp_q <= bad_slp;
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_oe_n  <= 1'b1;
      ack       <= 1'b0;
      busy      <= 1'b1;
      boot_done <= 1'b0;
      save_ok   <= 1'b0;
      save_fail <= 1'b0;
    end else begin
      scl_oe_n  <= ~(st_d == tsc_pkg::TSC_STRCH);
      ack       <= (st_q == tsc_pkg::TSC_STRCH) && ack_due;
      busy      <= (st_d != tsc_pkg::TSC_IDLE);
      boot_done <= (st_d != tsc_pkg::TSC_BOOT);
      save_ok   <= (st_q == tsc_pkg::TSC_SAVE) && save_end && !bad_slp_q;
      save_fail <= (st_q == tsc_pkg::TSC_SAVE) && save_end && bad_slp_q;
    end
  end

  // ------------------------------------------------------------
  // Scan with sample drop
  // ------------------------------------------------------------
  logic scan_q;
  logic dirty_q;
  logic keep;
  assign keep = scan_done && scan_q && !dirty_q && !bus_act;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_q  <= 1'b0;
      dirty_q <= 1'b0;
    end else begin
      if (scan_start) begin
        scan_q  <= 1'b1;
        dirty_q <= 1'b0;
      end else if (scan_done) begin
        scan_q  <= 1'b0;
      end else if (scan_q && bus_act) begin
        dirty_q <= 1'b1;
      end
    end
  end

  tsc_avg_if af ();
  assign af.smp_vld = keep;
  assign af.smp     = raw_cnt;
  assign af.avg_sel = avg_sel;
  tsc_avg u_avg (
    .clk (clk),
    .rst (rst),
    .f   (af.flt)
  );

  // Touch during boot with averaging on latches a stuck trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_vld    <= 1'b0;
      cnt        <= '0;
      trig_stuck <= 1'b0;
      base_frz   <= 1'b0;
    end else begin
      cnt_vld <= af.out_vld;
      if (af.out_vld) cnt <= af.out;
      if (st_q == tsc_pkg::TSC_BOOT && touch && avg_sel != tsc_pkg::AVG_OFF) begin
        trig_stuck <= 1'b1;
        base_frz   <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Acknowledge latency watch
  // ------------------------------------------------------------
  // Bounds run to thousands of cycles, so a counter stands in for a delay range
  localparam logic [15:0] NB_LIM = 16'(tsc_pkg::ACK_NORM_CYC);
  localparam logic [15:0] SB_LIM = 16'(tsc_pkg::ACK_SAVE_CYC);
  logic                             aw_q;
  logic                             aw_save_q;
  logic [15:0]                      aw_cnt_q;
  logic                             take;
  assign take = (st_q == tsc_pkg::TSC_IDLE) && acc_req;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q      <= 1'b0;
      aw_save_q <= 1'b0;
      aw_cnt_q  <= 16'h0000;
    end else if (take) begin
      aw_q      <= 1'b1;
      aw_save_q <= acc_save;
      aw_cnt_q  <= 16'h0001;
    end else if (ack) begin
      aw_q      <= 1'b0;
    end else if (aw_q) begin
      aw_cnt_q  <= aw_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_ack_norm;
    @(posedge clk) disable iff (rst)
      (aw_q && !aw_save_q && !ack) |-> (aw_cnt_q < NB_LIM);
  endproperty
  a_ack_norm: assert property (p_ack_norm) else $error("normal ack late");
  property p_ack_save;
    @(posedge clk) disable iff (rst)
      (aw_q && aw_save_q && !ack) |-> (aw_cnt_q < SB_LIM);
  endproperty
  a_ack_save: assert property (p_ack_save) else $error("save ack late");
  property p_save_busy;
    @(posedge clk) disable iff (rst)
      (ack && save_q) |-> busy [*8];
  endproperty
  a_save_busy: assert property (p_save_busy) else $error("idle during save");
  property p_fail;
    @(posedge clk) disable iff (rst)
      save_fail |-> $past(bad_slp_q) && !save_ok;
  endproperty
  a_fail: assert property (p_fail) else $error("save result wrong");
  property p_drop;
    @(posedge clk) disable iff (rst)
      (scan_done && dirty_q) |=> !af.smp_vld ##1 !cnt_vld;
  endproperty
  a_drop: assert property (p_drop) else $error("dirty sample kept");
  property p_stretch;
    @(posedge clk) disable iff (rst)
      (st_q == tsc_pkg::TSC_STRCH) |=> !scl_oe_n || ack;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock released early");
  property p_stuck;
    @(posedge clk) disable iff (rst)
      (st_q == tsc_pkg::TSC_BOOT && touch && avg_sel != tsc_pkg::AVG_OFF) |=> trig_stuck && base_frz;
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck trigger missing");
  property p_avg_off;
    @(posedge clk) disable iff (rst)
      (keep && avg_sel == tsc_pkg::AVG_OFF) |=> ##1 cnt_vld && cnt == $past(raw_cnt, 2);
  endproperty
  a_avg_off: assert property (p_avg_off) else $error("bypass count wrong");
  property p_boot;
    @(posedge clk) disable iff (rst)
      !boot_done |-> !ack;
  endproperty
  a_boot: assert property (p_boot) else $error("ack during boot");
  c_norm: cover property (@(posedge clk) disable iff (rst) ack && !save_q);
  c_save: cover property (@(posedge clk) disable iff (rst) save_ok);
  c_fail: cover property (@(posedge clk) disable iff (rst) save_fail);
  c_drop: cover property (@(posedge clk) disable iff (rst) scan_done && dirty_q);
endmodule : tsc_core

// ### tsc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bus host standing in for the controller
// ----------------------------------------
module tsc_host_model (
  input  wire logic       clk,
  input  wire logic       busy,
  input  wire logic       ack,
  input  wire logic       scl_oe_n,
  output logic            acc_req,
  output logic            acc_save,
  output logic [1:0]      sleep_sel
);
  initial begin
    acc_req   = 1'b0;
    acc_save  = 1'b0;
    sleep_sel = tsc_pkg::SLP_8HZ;
  end

  // Forcing a request while busy is only for refusal tests; a polite host waits
  task automatic access(input logic save, input logic [1:0] slp, input logic force_req,
                        input int maxw, output int lat, output int str);
    int n;
    n = 0;
    while (force_req !== 1'b1 && busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    acc_req   = 1'b1;
    acc_save  = save;
    sleep_sel = slp;
    @(posedge clk);
    #1 acc_req = 1'b0;
    acc_save = 1'b0;
    lat = 0;
    str = 0;
    while (ack !== 1'b1 && lat < maxw) begin
      if (scl_oe_n === 1'b0) str++;
      @(posedge clk);
      #1 lat++;
    end
    if (ack !== 1'b1) lat = -1;
  endtask : access
endmodule : tsc_host_model

// ### tsc_pkg.sv
package tsc_pkg;
  localparam int CLK_MHZ         = 50;
  localparam int ACK_MAX_NORM_US = 140;
  localparam int ACK_MAX_SAVE_US = 100;
  localparam int ACK_NORM_CYC    = ACK_MAX_NORM_US * CLK_MHZ;
  localparam int ACK_SAVE_CYC    = ACK_MAX_SAVE_US * CLK_MHZ;
  localparam int ACK_CNT_W       = 13;
  // Sleep interval codes
  localparam logic [1:0] SLP_512HZ = 2'h0;
  localparam logic [1:0] SLP_64HZ  = 2'h1;
  localparam logic [1:0] SLP_8HZ   = 2'h2;
  localparam logic [1:0] SLP_1HZ   = 2'h3;
  // Averaging selection: 0 off, 1..4 -> 2,4,8,16 samples
  localparam logic [2:0] AVG_OFF   = 3'h0;
  localparam int CNT_W             = 16;
  localparam int ACC_W             = 20;
  localparam int BOOT_CYC          = 1000;
  localparam int SAVE_CYC          = 5000;
  typedef enum logic [4:0] {
    TSC_BOOT  = 5'h01,
    TSC_IDLE  = 5'h02,
    TSC_STRCH = 5'h04,
    TSC_SAVE  = 5'h08,
    TSC_DONE  = 5'h10
  } tsc_state_t;
endpackage : tsc_pkg
